// >>> core/sram_defs.svh
// Shared constants of the synchronous pass-through memory.
// Assumes inclusion by bare name from the package and the core module.
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

`define SRAM_WORDS      262144
`define SRAM_ADDR_W     18
`define SRAM_DATA_W     4
`define SRAM_ADDR_RST   18'h00000
`define SRAM_DATA_RST   4'h0
`define SRAM_CTRL_RST_N 1'b1

`endif

// >>> core/sram_pkg.sv
// Types of the synchronous pass-through memory.
// Assumes sram_defs.svh is on the include path.
`include "sram_defs.svh"

package sram_pkg;

  typedef logic [`SRAM_ADDR_W-1:0] word_addr_t;
  typedef logic [`SRAM_DATA_W-1:0] word_t;

  // One cycle's captured request from the host
  typedef struct packed {
    word_addr_t addr;
    word_t      data;
    logic       write_req_n;
    logic       write_gate_n;
  } req_t;

  // Output pin state
  typedef struct packed {
    word_t data;
    logic  oe;
  } out_t;

endpackage

// >>> core/sync_sram_passthrough_x4.sv
// Synchronous 256K x 4 memory with registered inputs, pass-through and
// transparent write. Assumes the host drives all inputs from ref_clk logic.
//
// Behaviour
// - Holds 262,144 words of 4 bits, chosen by an 18-bit word address.
// - Address, data and controls are captured only at the rising clock edge.
// - Never deselects; write gate high leaves reads and output driving alone.
// - Write gate sampled high only blocks the array write that cycle.
// - Input data forwarding to outputs is on for every write request, gated or not.
// - Gate, request and drive all low: store the data and show it.
// - Data captured at one edge appears on outputs after the next edge.
// - Outputs float only in reset or when the drive input was sampled high.
// - Read shows the word at the registered address, else holds last data.
// - Separate 4-bit write data input and 4-bit read data output.
`timescale 1ns/1ps
`include "sram_defs.svh"

module sync_sram_passthrough_x4
  import sram_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  // Host request pins
  input  wire logic [`SRAM_ADDR_W-1:0] word_address,
  input  wire logic [`SRAM_DATA_W-1:0] write_data,
  input  wire logic                    write_req_n,
  input  wire logic                    write_gate_n,
  input  wire logic                    out_drive_n,
  // Output pins, enable high while driving
  output logic      [`SRAM_DATA_W-1:0] read_data,
  output logic                         read_data_oe
);

  req_t   req_q;
  req_t   req_d;
  out_t   out_q;
  out_t   out_d;
  word_t  mem [`SRAM_WORDS];
  word_t  rd_word;
  logic   mem_we;

  // Input capture stage
  always_comb begin
    req_d.addr         = word_address;
    req_d.data         = write_data;
    req_d.write_req_n  = write_req_n;
    req_d.write_gate_n = write_gate_n;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      req_q.addr         <= `SRAM_ADDR_RST;
      req_q.data         <= `SRAM_DATA_RST;
      req_q.write_req_n  <= `SRAM_CTRL_RST_N;
      req_q.write_gate_n <= `SRAM_CTRL_RST_N;
    end else begin
      req_q <= req_d;
    end
  end

  // Array: the gate only qualifies the write, nothing else
  always_comb begin
    mem_we  = !req_q.write_req_n && !req_q.write_gate_n;
    rd_word = mem[req_q.addr];
  end

  // No reset on the array: contents are undefined at power-up anyway
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[req_q.addr] <= req_q.data;
    end
  end

  // Output stage: drive sampled one edge after request and gate
  always_comb begin
    out_d = out_q;
    if (!out_drive_n) begin
      out_d.oe = 1'b1;
      if (!req_q.write_req_n) begin
        out_d.data = req_q.data;
      end else begin
        out_d.data = rd_word;
      end
    end else begin
      out_d.oe = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_q.data <= `SRAM_DATA_RST;
      out_q.oe   <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  assign read_data    = out_q.data;
  assign read_data_oe = out_q.oe;

  // Checks

  property p_capture;
    @(posedge ref_clk) disable iff (!nrst)
      1'b1 |=> (req_q.addr == $past(word_address)) && (req_q.data == $past(write_data));
  endproperty
  a_capture: assert property (p_capture)
    else $error("captured address or data differs from pins");

  property p_store;
    @(posedge ref_clk) disable iff (!nrst)
      (!write_req_n && !write_gate_n) ##1 1'b1 |=>
        (mem[$past(word_address, 2)] == $past(write_data, 2));
  endproperty
  a_store: assert property (p_store)
    else $error("write did not store the word");

  property p_gate_blocks;
    @(posedge ref_clk) disable iff (!nrst)
      (!write_req_n && write_gate_n) |=> !mem_we;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks)
    else $error("gated write reached the array");

  property p_read_no_write;
    @(posedge ref_clk) disable iff (!nrst)
      write_req_n |=> !mem_we;
  endproperty
  a_read_no_write: assert property (p_read_no_write)
    else $error("read cycle wrote the array");

  property p_pass_through;
    @(posedge ref_clk) disable iff (!nrst)
      (!write_req_n) ##1 (!out_drive_n) |=> read_data_oe && (read_data == $past(write_data, 2));
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("pass-through data missing one cycle later");

  property p_transparent;
    @(posedge ref_clk) disable iff (!nrst)
      (!write_req_n && !write_gate_n) ##1 (!out_drive_n) |=>
        read_data_oe && (read_data == $past(write_data, 2))
        && (mem[$past(word_address, 2)] == $past(write_data, 2));
  endproperty
  a_transparent: assert property (p_transparent)
    else $error("transparent write did not show input data");

  property p_drive_despite_gate;
    @(posedge ref_clk) disable iff (!nrst)
      (write_gate_n && !out_drive_n) |=> read_data_oe;
  endproperty
  a_drive_despite_gate: assert property (p_drive_despite_gate)
    else $error("gate high stopped output driving");

  property p_float;
    @(posedge ref_clk) disable iff (!nrst)
      !read_data_oe |-> $past(out_drive_n);
  endproperty
  a_float: assert property (p_float)
    else $error("outputs floated without drive sampled high");

  property p_read;
    @(posedge ref_clk) disable iff (!nrst)
      (write_req_n) ##1 (!out_drive_n) |=> read_data == $past(rd_word);
  endproperty
  a_read: assert property (p_read)
    else $error("read data is not the addressed word");

  property p_hold;
    @(posedge ref_clk) disable iff (!nrst)
      out_drive_n ##1 out_drive_n |=> $stable(read_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output data changed while not driven");

  // Capture and reset behaviour

  property p_capture_ctrl;
    @(posedge ref_clk) disable iff (!nrst)
      $past(nrst) |-> (req_q.write_req_n == $past(write_req_n))
        && (req_q.write_gate_n == $past(write_gate_n));
  endproperty
  a_capture_ctrl: assert property (p_capture_ctrl)
    else $error("captured controls differ from pins");

  // Reset is not gated off here: the quiet outputs are the point
  property p_reset_quiet;
    @(posedge ref_clk)
      !nrst |=> !read_data_oe && (read_data == `SRAM_DATA_RST);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active during reset");

  property p_first_edge;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(nrst) |-> !read_data_oe && !mem_we;
  endproperty
  a_first_edge: assert property (p_first_edge)
    else $error("activity at first edge after reset");

  // Drive and float

  property p_drive_on;
    @(posedge ref_clk) disable iff (!nrst)
      !out_drive_n |=> read_data_oe;
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("drive sampled low did not enable outputs");

  property p_drive_off;
    @(posedge ref_clk) disable iff (!nrst)
      out_drive_n |=> !read_data_oe;
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("drive sampled high left outputs enabled");

  property p_float_hold;
    @(posedge ref_clk) disable iff (!nrst)
      out_drive_n |=> $stable(read_data);
  endproperty
  a_float_hold: assert property (p_float_hold)
    else $error("floated output data did not hold");

  property p_read_float;
    @(posedge ref_clk) disable iff (!nrst)
      write_req_n ##1 out_drive_n |=> !read_data_oe;
  endproperty
  a_read_float: assert property (p_read_float)
    else $error("read with drive high was driven");

  property p_write_float;
    @(posedge ref_clk) disable iff (!nrst)
      (!write_req_n && !write_gate_n) ##1 out_drive_n |=>
        !read_data_oe && (mem[$past(word_address, 2)] == $past(write_data, 2));
  endproperty
  a_write_float: assert property (p_write_float)
    else $error("floated write lost its word");

  property p_nop;
    @(posedge ref_clk) disable iff (!nrst)
      (!write_req_n && write_gate_n) ##1 out_drive_n |=> !read_data_oe && $stable(read_data);
  endproperty
  a_nop: assert property (p_nop)
    else $error("idle cycle touched the outputs");

  // Gate has no say beyond the array write

  property p_gated_pass;
    @(posedge ref_clk) disable iff (!nrst)
      (!write_req_n && write_gate_n) ##1 (!out_drive_n) |=>
        read_data_oe && (read_data == $past(write_data, 2));
  endproperty
  a_gated_pass: assert property (p_gated_pass)
    else $error("gate high stopped pass-through");

  property p_gated_read;
    @(posedge ref_clk) disable iff (!nrst)
      (write_req_n && !write_gate_n) ##1 (!out_drive_n) |=> read_data_oe;
  endproperty
  a_gated_read: assert property (p_gated_read)
    else $error("read with gate low was not driven");

  property p_read_gate_high;
    @(posedge ref_clk) disable iff (!nrst)
      (write_req_n && write_gate_n) ##1 (!out_drive_n) |=> read_data_oe;
  endproperty
  a_read_gate_high: assert property (p_read_gate_high)
    else $error("read with gate high was not driven");

  property p_no_gate_no_we;
    @(posedge ref_clk) disable iff (!nrst)
      write_gate_n |=> !mem_we;
  endproperty
  a_no_gate_no_we: assert property (p_no_gate_no_we)
    else $error("array written with gate high");

  property p_we_source;
    @(posedge ref_clk) disable iff (!nrst)
      $past(nrst) && mem_we |-> $past(!write_req_n && !write_gate_n);
  endproperty
  a_we_source: assert property (p_we_source)
    else $error("array write without a gated request");

  // Timing of stored and forwarded words

  property p_read_stored;
    @(posedge ref_clk) disable iff (!nrst)
      (!write_req_n && !write_gate_n)
        ##1 (write_req_n && (word_address == $past(word_address)))
        ##1 (!out_drive_n) |=> read_data == $past(write_data, 3);
  endproperty
  a_read_stored: assert property (p_read_stored)
    else $error("read after write missed the stored word");

  property p_pass_stands;
    @(posedge ref_clk) disable iff (!nrst)
      (!write_req_n) ##1 (!out_drive_n) ##1 out_drive_n |=>
        !read_data_oe && (read_data == $past(write_data, 3));
  endproperty
  a_pass_stands: assert property (p_pass_stands)
    else $error("forwarded word not held after float");

endmodule // sync_sram_passthrough_x4

// >>> dv/host_model.sv
// Host controller model that issues one request per op.
// Assumes a free-running ref_clk and nrst already released.
`timescale 1ns/1ps

module host_model
  import sram_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // Request pins
  output word_addr_t word_address,
  output word_t      write_data,
  output logic       write_req_n,
  output logic       write_gate_n,
  output logic       out_drive_n
);
  initial {word_address, write_data, write_req_n, write_gate_n, out_drive_n} = 25'h0000007;

  // Drive follows its request by one edge
  task automatic op(input word_addr_t a, input word_t d, input logic w, g, o);
    @(posedge ref_clk);
    word_address <= a;
    write_data   <= d;
    write_req_n  <= w;
    write_gate_n <= g;
    @(posedge ref_clk);
    out_drive_n  <= o;
    write_req_n  <= 1'b1;
    write_gate_n <= 1'b1;
    // Released data shows its inverse, not a stale copy
    write_data   <= ~d;
    @(posedge ref_clk);
    #1;
  endtask
endmodule // host_model

// >>> dv/sync_sram_passthrough_x4_tb.sv
// Self-checking bench of the pass-through memory.
// Assumes host_model drives every request pin.
`timescale 1ns/1ps

module sync_sram_passthrough_x4_tb
  import sram_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       nrst    = 1'b0;
  word_addr_t word_address;
  word_t      write_data;
  word_t      read_data;
  logic       write_req_n, write_gate_n, out_drive_n, read_data_oe;
  int         failures    = 0;
  int         comparisons = 0;

  initial forever #5 ref_clk = ~ref_clk;

  sync_sram_passthrough_x4 u_sync_sram_passthrough_x4 (.ref_clk(ref_clk), .nrst(nrst),
    .word_address(word_address), .write_data(write_data), .write_req_n(write_req_n),
    .write_gate_n(write_gate_n), .out_drive_n(out_drive_n), .read_data(read_data),
    .read_data_oe(read_data_oe));
  host_model u_host_model (.ref_clk(ref_clk), .word_address(word_address),
    .write_data(write_data), .write_req_n(write_req_n), .write_gate_n(write_gate_n),
    .out_drive_n(out_drive_n));

  task automatic check(input logic [4:0] seen, exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // One op, then enable and data as seen after the drive edge
  task automatic xfer(input word_addr_t a, input word_t d, input logic w, g, o,
                      input logic [4:0] exp, input string msg);
    u_host_model.op(a, d, w, g, o);
    check({read_data_oe, read_data}, exp, msg);
  endtask

  task automatic t_write();
    xfer(18'h00000, 4'h5, 1'b0, 1'b0, 1'b0, 5'h15, "write low");
    xfer(18'h3ffff, 4'ha, 1'b0, 1'b0, 1'b0, 5'h1a, "write top");
    xfer(18'h00000, 4'h0, 1'b1, 1'b1, 1'b0, 5'h15, "read low");
    xfer(18'h3ffff, 4'h0, 1'b1, 1'b1, 1'b0, 5'h1a, "read top");
    $display("test write done");
  endtask

  task automatic t_gate();
    xfer(18'h00000, 4'hc, 1'b0, 1'b1, 1'b0, 5'h1c, "gated pass");
    xfer(18'h00000, 4'h0, 1'b1, 1'b0, 1'b0, 5'h15, "gated kept");
    xfer(18'h00000, 4'h0, 1'b1, 1'b1, 1'b0, 5'h15, "read again");
    $display("test gate done");
  endtask

  task automatic t_float();
    xfer(18'h00000, 4'h3, 1'b0, 1'b0, 1'b1, 5'h05, "write float");
    xfer(18'h00000, 4'h0, 1'b1, 1'b1, 1'b0, 5'h13, "float stored");
    xfer(18'h00000, 4'h9, 1'b0, 1'b1, 1'b1, 5'h03, "nop float");
    xfer(18'h00000, 4'h0, 1'b1, 1'b0, 1'b0, 5'h13, "nop kept");
    $display("test float done");
  endtask

  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    check({read_data_oe, read_data}, 5'h00, "reset");
    @(posedge ref_clk);
    nrst <= 1'b1;
    t_write();
    t_gate();
    t_float();
    summarize();
  end

  // Tests need about 40 cycles; 2000 leaves wide margin
  initial begin
    #20000;
    failures++;
    summarize();
  end
endmodule // sync_sram_passthrough_x4_tb
